// File: common/osc_ctrl_pkg.sv
// Package: register map, field layout, reset values and encodings for the oscillator control block
package osc_ctrl_pkg;
	// Register byte offsets (APB, one aligned word each)
	localparam logic [7:0]  OFS_OSC_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_CLK_DIV    = 8'h04;
	localparam logic [7:0]  OFS_PLL_FBD    = 8'h08;
	localparam logic [7:0]  OFS_RC_TRIM    = 8'h0C;
	localparam logic [7:0]  OFS_UNLOCK     = 8'h10;
	// Unlock register: bit 0 qualifies high byte, bit 1 low byte
	localparam int          UNLK_HI_BIT    = 0;
	localparam int          UNLK_LO_BIT    = 1;
	// Oscillator control field positions
	localparam int          CUR_SRC_LSB    = 12;
	localparam int          NEW_SRC_LSB    = 8;
	localparam int          LOCK_BIT       = 5;
	localparam int          CFAIL_BIT      = 3;
	localparam int          SEC_EN_BIT     = 1;
	localparam int          SWREQ_BIT      = 0;
	// Clock divisor field positions
	localparam int          RECOVER_BIT    = 15;
	localparam int          RATIO_LSB      = 12;
	localparam int          REDEN_BIT      = 11;
	localparam int          FRCPS_LSB      = 8;
	localparam int          POST_LSB       = 6;
	localparam int          PRE_LSB        = 0;
	// Reset values
	localparam logic [15:0] CLK_DIV_RST    = 16'h3040;
	localparam logic [8:0]  PLL_FBD_RST    = 9'h030;
	localparam logic [5:0]  RC_TRIM_RST    = 6'h00;
	// Timing
	localparam int          SETTLE_CYCLES  = 10;
	localparam logic [3:0]  SETTLE_LAST    = 4'h9;
	// Source encodings
	typedef enum logic [2:0] {
		SRC_FAST     = 3'b000,
		SRC_FAST_PLL = 3'b001,
		SRC_PRI      = 3'b010,
		SRC_PRI_PLL  = 3'b011,
		SRC_SEC      = 3'b100,
		SRC_SLOW_RC  = 3'b101,
		SRC_FAST_D16 = 3'b110,
		SRC_FAST_PS  = 3'b111
	} osc_src_t;
	// Switch sequencer states
	typedef enum logic [1:0] {
		SW_IDLE   = 2'b00,
		SW_START  = 2'b01,
		SW_SETTLE = 2'b10
	} sw_state_t;
endpackage : osc_ctrl_pkg

// File: rtl/osc_switch_pll_divider_ctrl.sv
// Oscillator switch, PLL divider and clock ratio control with APB register access
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Interrupt clears reduction enable when recover set
// [RULE_02] Ratio field divides CPU by 2^code
// [RULE_03] Ratio applies only while enable set
// [RULE_04] Fast RC postscaler 1..64, code 7 256
// [RULE_05] PLL postscaler 2,4,reserved,8
// [RULE_06] PLL prescaler equals field plus two
// [RULE_07] Feedback multiplier equals field plus two
// [RULE_08] Trim is two's-complement frequency offset
// [RULE_09] Divisor registers reset only on power-on
// [RULE_10] Config bit one disables switching, monitor
// [RULE_11] Switching disabled: request held zero
// [RULE_12] Software unlocks, writes new source, requests
// [RULE_13] Equal sources abort, clearing request
// [RULE_14] Valid switch clears lock and fail
// [RULE_15] Wait for start-up timer or lock
// [RULE_16] Count ten new-clock cycles before changeover
// [RULE_17] Completion clears request, copies new source
// [RULE_18] Turn off old source, keep exceptions
// [RULE_19] No direct PLL-to-PLL switch; the sequencer does not block one
// [RULE_20] Monitor keeps low-power RC running
// [RULE_21] Failure raises trap, falls to fast RC
// [RULE_22] PLL in use falls to RC-PLL
// [RULE_23] Source field encoding of eight modes
// [RULE_24] Fail flag reads one after failure
// [RULE_25] Lock bit mirrors PLL lock status
// [RULE_26] Control writes need byte unlock first
module osc_switch_pll_divider_ctrl (
	// Clock and resets
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire logic                  por_rst,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// Configuration straps
	input  wire logic                  switch_monitor_cfg,
	input  wire logic [2:0]            initial_source_cfg,
	input  wire logic                  watchdog_on,
	// Events and oscillator status (asynchronous)
	input  wire logic                  irq_event,
	input  wire logic                  pll_locked,
	input  wire logic                  osc_startup_done,
	input  wire logic                  new_clk_tick,
	input  wire logic                  osc_failed,
	// Clock tree controls
	output logic [2:0]                 sys_clk_sel,
	output logic [7:0]                 cpu_div_ratio,
	output logic [8:0]                 fast_rc_div,
	output logic [3:0]                 pll_post_div,
	output logic [5:0]                 pll_pre_div,
	output logic [9:0]                 pll_mult,
	output logic [5:0]                 rc_trim_code,
	// Oscillator enables and trap
	output logic [7:0]                 osc_run_en,
	output logic                       slow_rc_run,
	output logic                       clk_fail_trap
);
	import osc_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [4:0] sync1_q;          // First stage, read only by second
	logic [4:0] sync2_q;          // Safe copies
	logic       tick_prev_q;      // Edge detect of new clock tick
	logic       fail_prev_q;      // Edge detect of failure
	logic       irq_s, lock_s, start_s, tick_s, fail_s;
	always_ff @(posedge mclk) begin
		sync1_q <= {osc_failed, new_clk_tick, osc_startup_done, pll_locked, irq_event};
		sync2_q <= sync1_q;
		tick_prev_q <= sync2_q[3];
		fail_prev_q <= sync2_q[4];
	end
	assign irq_s  = sync2_q[0];
	assign lock_s = sync2_q[1];
	assign start_s = sync2_q[2];
	assign tick_s = sync2_q[3] & ~tick_prev_q;
	assign fail_s = sync2_q[4] & ~fail_prev_q;

	////////////////////////////////////////////////////////////////////////////
	// Helper functions
	// Power-of-two divisor as one-hot in a 9-bit field
	function automatic logic [8:0] rc_div_f(input logic [2:0] code);
		rc_div_f = (code == 3'h7) ? 9'h100 : 9'(9'h001 << code); // [RULE_04]
	endfunction : rc_div_f
	// Source uses the PLL
	function automatic logic uses_pll_f(input logic [2:0] s);
		uses_pll_f = (s == SRC_FAST_PLL) || (s == SRC_PRI_PLL);
	endfunction : uses_pll_f
	// Source is a crystal needing the start-up timer
	function automatic logic needs_timer_f(input logic [2:0] s);
		needs_timer_f = (s == SRC_PRI) || (s == SRC_PRI_PLL) || (s == SRC_SEC);
	endfunction : needs_timer_f

	////////////////////////////////////////////////////////////////////////////
	// APB decode
	logic       wr_en, rd_en;
	logic       hit;               // Mapped address
	assign pready  = 1'b1;          // Zero wait states
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign hit     = (paddr == OFS_OSC_CTRL) || (paddr == OFS_CLK_DIV) || (paddr == OFS_PLL_FBD)
		|| (paddr == OFS_RC_TRIM) || (paddr == OFS_UNLOCK);
	assign pslverr = psel & penable & ~hit;

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [15:0] clk_div_q;       // Divisor register
	logic [8:0]  pll_fbd_q;       // Feedback field
	logic [5:0]  trim_q;          // Trim field
	logic [2:0]  cur_src_q;       // Current source
	logic [2:0]  new_src_q;       // Requested source
	logic        swreq_q;         // Switch request
	logic        cfail_q;         // Clock fail flag
	logic        sec_en_q;        // Secondary oscillator enable
	logic        unlk_hi_q;       // High byte qualified
	logic        unlk_lo_q;       // Low byte qualified
	logic        sw_allowed;      // Config permits switching
	sw_state_t   st_q;            // Switch sequencer
	logic [3:0]  settle_q;        // New clock cycle counter
	logic [2:0]  prev_src_q;      // Source being retired
	logic        pll_in_use;
	logic        osc_wr_hi, osc_wr_lo;

	assign sw_allowed = ~switch_monitor_cfg; // [RULE_10]
	assign pll_in_use = uses_pll_f(cur_src_q);
	assign osc_wr_hi  = wr_en && (paddr == OFS_OSC_CTRL) && unlk_hi_q; // [RULE_26]
	assign osc_wr_lo  = wr_en && (paddr == OFS_OSC_CTRL) && unlk_lo_q; // [RULE_26]

	// Divisor, feedback and trim: power-on reset only
	always_ff @(posedge mclk) begin
		if (por_rst) begin // [RULE_09]
			clk_div_q <= CLK_DIV_RST;
			pll_fbd_q <= PLL_FBD_RST;
			trim_q    <= RC_TRIM_RST;
		end else begin
			if (wr_en && paddr == OFS_CLK_DIV) begin
				clk_div_q <= pwdata[15:0] & 16'hFFDF;
			end
			// Interrupt recovery wins over a same-cycle write
			if (clk_div_q[RECOVER_BIT] && irq_s) begin
				clk_div_q[REDEN_BIT] <= 1'b0; // [RULE_01]
			end
			if (wr_en && paddr == OFS_PLL_FBD) begin
				pll_fbd_q <= pwdata[8:0]; // [RULE_07]
			end
			if (wr_en && paddr == OFS_RC_TRIM) begin
				trim_q <= pwdata[5:0]; // [RULE_08]
			end
		end
	end

	// Unlock qualifiers: one write each, consumed by the next control write
	always_ff @(posedge mclk) begin
		if (sys_rst || por_rst) begin
			unlk_hi_q <= 1'b0;
			unlk_lo_q <= 1'b0;
		end else if (wr_en && paddr == OFS_UNLOCK) begin
			unlk_hi_q <= pwdata[UNLK_HI_BIT];
			unlk_lo_q <= pwdata[UNLK_LO_BIT];
		end else if (wr_en && paddr == OFS_OSC_CTRL) begin
			unlk_hi_q <= 1'b0; // [RULE_26]
			unlk_lo_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Oscillator control and switch sequencer (power-on reset only)
	// Reset source taken from straps on the first cycle after power-on release
	logic por_seen_q;
	always_ff @(posedge mclk) begin
		if (por_rst) begin
			st_q       <= SW_IDLE;
			por_seen_q <= 1'b0;
			cur_src_q  <= SRC_FAST;
			new_src_q  <= SRC_FAST;
			swreq_q    <= 1'b0;
			cfail_q    <= 1'b0;
			sec_en_q   <= 1'b0;
			settle_q   <= 4'h0;
			prev_src_q <= SRC_FAST;
		end else if (!por_seen_q) begin
			por_seen_q <= 1'b1;
			cur_src_q  <= initial_source_cfg; // [RULE_11]
			new_src_q  <= initial_source_cfg;
		end else begin
			if (osc_wr_hi) begin
				new_src_q <= pwdata[NEW_SRC_LSB +: 3]; // [RULE_12]
			end
			if (osc_wr_lo) begin
				sec_en_q <= pwdata[SEC_EN_BIT];
				if (pwdata[CFAIL_BIT] == 1'b0) begin
					cfail_q <= 1'b0;
				end
				if (sw_allowed && st_q == SW_IDLE && pwdata[SWREQ_BIT]) begin
					swreq_q <= 1'b1;
				end
			end
			if (!sw_allowed) begin
				swreq_q <= 1'b0; // [RULE_11]
				cur_src_q <= initial_source_cfg; // [RULE_11]
			end
			unique case (st_q)
				SW_IDLE: begin
					if (sw_allowed && swreq_q) begin
						if (cur_src_q == new_src_q) begin
							swreq_q <= 1'b0; // [RULE_13]
						end else begin
							cfail_q <= 1'b0; // [RULE_14]
							st_q    <= SW_START;
						end
					end
				end
				SW_START: begin
					// [RULE_15]
					if ((!needs_timer_f(new_src_q) || start_s) && (!uses_pll_f(new_src_q) || lock_s)) begin
						settle_q <= 4'h0;
						st_q     <= SW_SETTLE;
					end
				end
				SW_SETTLE: begin
					if (tick_s) begin
						if (settle_q == SETTLE_LAST) begin // [RULE_16]
							prev_src_q <= cur_src_q;
							cur_src_q  <= new_src_q; // [RULE_17]
							swreq_q    <= 1'b0; // [RULE_17]
							st_q       <= SW_IDLE;
						end else begin
							settle_q <= settle_q + 4'h1;
						end
					end
				end
				// Unused code: fall back to idle rather than hang
				default: begin
					st_q <= SW_IDLE;
				end
			endcase
			// Fail-safe fallback overrides any switch in progress
			if (sw_allowed && fail_s) begin
				cfail_q   <= 1'b1; // [RULE_24]
				cur_src_q <= pll_in_use ? SRC_FAST_PLL : SRC_FAST; // [RULE_21] [RULE_22]
				new_src_q <= pll_in_use ? SRC_FAST_PLL : SRC_FAST;
				swreq_q   <= 1'b0;
				st_q      <= SW_IDLE;
			end
		end
	end

	// Lock status cleared at switch start, else follows the PLL
	logic lock_q;
	always_ff @(posedge mclk) begin
		if (sys_rst || por_rst) begin
			lock_q <= 1'b0;
		end else if (st_q == SW_IDLE && swreq_q && cur_src_q != new_src_q) begin
			lock_q <= 1'b0; // [RULE_14]
		end else begin
			lock_q <= lock_s && (uses_pll_f(cur_src_q) || uses_pll_f(new_src_q)); // [RULE_25]
		end
	end

	// Fail trap pulse
	always_ff @(posedge mclk) begin
		if (sys_rst || por_rst) begin
			clk_fail_trap <= 1'b0;
		end else begin
			clk_fail_trap <= sw_allowed && fail_s; // [RULE_21]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock tree outputs from flip-flops
	always_ff @(posedge mclk) begin
		if (sys_rst || por_rst) begin
			sys_clk_sel   <= SRC_FAST;
			cpu_div_ratio <= 8'h01;
			fast_rc_div   <= 9'h001;
			pll_post_div  <= 4'h4;
			pll_pre_div   <= 6'h02;
			pll_mult      <= 10'h032;
			rc_trim_code  <= 6'h00;
			osc_run_en    <= 8'h01;
			slow_rc_run   <= 1'b0;
		end else begin
			sys_clk_sel <= cur_src_q; // [RULE_23]
			cpu_div_ratio <= clk_div_q[REDEN_BIT] ? 8'(8'h01 << clk_div_q[RATIO_LSB +: 3]) : 8'h01; // [RULE_02] [RULE_03]
			fast_rc_div <= rc_div_f(clk_div_q[FRCPS_LSB +: 3]); // [RULE_04]
			unique case (clk_div_q[POST_LSB +: 2]) // [RULE_05]
				2'b00: pll_post_div <= 4'h2;
				2'b01: pll_post_div <= 4'h4;
				2'b11: pll_post_div <= 4'h8;
				2'b10: pll_post_div <= 4'h8;
			endcase
			pll_pre_div  <= 6'({1'b0, clk_div_q[PRE_LSB +: 5]} + 6'h02); // [RULE_06]
			pll_mult     <= 10'({1'b0, pll_fbd_q} + 10'h002); // [RULE_07]
			rc_trim_code <= trim_q; // [RULE_08]
			// Current and incoming source run, plus secondary while enabled; old one dropped at changeover [RULE_18]
			osc_run_en <= 8'(8'h01 << cur_src_q) | ((st_q != SW_IDLE) ? 8'(8'h01 << new_src_q) : 8'h00)
				| (sec_en_q ? 8'(8'h01 << SRC_SEC) : 8'h00);
			slow_rc_run <= watchdog_on || sw_allowed; // [RULE_18] [RULE_20]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux
	always_ff @(posedge mclk) begin
		if (sys_rst || por_rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFS_OSC_CTRL: prdata <= {16'h0000, 1'b0, cur_src_q, 1'b0, new_src_q, 2'b00, lock_q,
					1'b0, cfail_q, 1'b0, sec_en_q, swreq_q};
				OFS_CLK_DIV:  prdata <= {16'h0000, clk_div_q};
				OFS_PLL_FBD:  prdata <= {23'h000000, pll_fbd_q};
				OFS_RC_TRIM:  prdata <= {26'h0000000, trim_q};
				OFS_UNLOCK:   prdata <= {30'h00000000, unlk_lo_q, unlk_hi_q};
				default:      prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_recover_clear;
		@(posedge mclk) disable iff (por_rst) (clk_div_q[RECOVER_BIT] && irq_s) |=> !clk_div_q[REDEN_BIT];
	endproperty
	a_recover_clear: assert property (p_recover_clear) else $error("recover did not clear enable"); // [RULE_01]
	property p_ratio_one;
		@(posedge mclk) disable iff (sys_rst || por_rst) !clk_div_q[REDEN_BIT] |=> cpu_div_ratio == 8'h01;
	endproperty
	a_ratio_one: assert property (p_ratio_one) else $error("ratio not forced 1:1"); // [RULE_03]
	property p_mult;
		@(posedge mclk) disable iff (sys_rst || por_rst) 1'b1 |=> pll_mult == 10'({1'b0, $past(pll_fbd_q)} + 10'h002);
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier wrong"); // [RULE_07]
	property p_disabled_noreq;
		@(posedge mclk) disable iff (por_rst) (switch_monitor_cfg && por_seen_q) |=> !swreq_q;
	endproperty
	a_disabled_noreq: assert property (p_disabled_noreq) else $error("request set while disabled"); // [RULE_11]
	property p_abort;
		@(posedge mclk) disable iff (por_rst) (st_q == SW_IDLE && swreq_q && cur_src_q == new_src_q) |=> !swreq_q;
	endproperty
	a_abort: assert property (p_abort) else $error("redundant switch not aborted"); // [RULE_13]
	property p_start_clear;
		@(posedge mclk) disable iff (por_rst)
			(sw_allowed && st_q == SW_IDLE && swreq_q && cur_src_q != new_src_q && !fail_s) |=> !cfail_q && st_q == SW_START;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("switch start did not clear fail"); // [RULE_14]
	property p_complete;
		@(posedge mclk) disable iff (por_rst) (st_q == SW_SETTLE && tick_s && settle_q == SETTLE_LAST && !fail_s)
			|=> !swreq_q && cur_src_q == $past(new_src_q);
	endproperty
	a_complete: assert property (p_complete) else $error("switch completion wrong"); // [RULE_17]
	property p_fallback;
		@(posedge mclk) disable iff (por_rst) (sw_allowed && fail_s && por_seen_q)
			|=> cfail_q && cur_src_q == ($past(pll_in_use) ? SRC_FAST_PLL : SRC_FAST);
	endproperty
	a_fallback: assert property (p_fallback) else $error("fail-safe fallback wrong"); // [RULE_22]
	// A crystal must not reach the settle count before its start-up timer
	property p_timer_wait;
		@(posedge mclk) disable iff (por_rst)
			(st_q == SW_START && needs_timer_f(new_src_q) && !start_s) |=> st_q != SW_SETTLE;
	endproperty
	a_timer_wait: assert property (p_timer_wait) else $error("switch skipped start-up wait"); // [RULE_15]
	property p_trap;
		@(posedge mclk) disable iff (sys_rst || por_rst) (sw_allowed && fail_s) |=> clk_fail_trap;
	endproperty
	a_trap: assert property (p_trap) else $error("failure raised no trap"); // [RULE_21]
	// Retired source is switched off unless it is the kept secondary
	property p_old_off;
		@(posedge mclk) disable iff (sys_rst || por_rst)
			(st_q == SW_IDLE && prev_src_q != cur_src_q && !(sec_en_q && prev_src_q == SRC_SEC))
			|=> !osc_run_en[prev_src_q];
	endproperty
	a_old_off: assert property (p_old_off) else $error("retired source still enabled"); // [RULE_18]
endmodule : osc_switch_pll_divider_ctrl

// File: verification/osc_switch_pll_divider_ctrl_bench.sv
// Self-checking bench for the oscillator switch, divider and clock ratio control block
`timescale 1ns/1ps
module osc_switch_pll_divider_ctrl_bench;
	import osc_ctrl_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	// Stimulus and observed signals
	logic        mclk               = 1'b0;  // 200 MHz clock
	logic        sys_rst            = 1'b1;  // Warm reset
	logic        por_rst            = 1'b1;  // Power-on reset
	logic        psel               = 1'b0;  // APB select
	logic        penable            = 1'b0;  // APB access phase
	logic        pwrite             = 1'b0;  // APB direction
	logic [7:0]  paddr              = 8'h00; // APB byte address
	logic [31:0] pwdata             = 32'h0; // APB write data
	logic        switch_monitor_cfg = 1'b1;  // Switching off at start
	logic [2:0]  initial_source_cfg = 3'h0;  // Strap source
	logic        watchdog_on        = 1'b0;  // Watchdog request
	logic        irq_event          = 1'b0;  // Interrupt level
	logic        pll_locked         = 1'b0;  // PLL lock status
	logic        osc_startup_done   = 1'b0;  // Start-up timer expired
	logic        new_clk_tick       = 1'b0;  // New clock edge
	logic        osc_failed         = 1'b0;  // Failure detect
	logic        pready;                     // Slave answer
	logic [31:0] prdata;                     // Read data
	logic        pslverr;                    // Unmapped access
	logic [2:0]  sys_clk_sel;                // Active source
	logic [7:0]  cpu_div_ratio;              // CPU ratio
	logic [8:0]  fast_rc_div;                // Fast RC divisor
	logic [3:0]  pll_post_div;               // PLL postscaler
	logic [5:0]  pll_pre_div;                // PLL prescaler
	logic [9:0]  pll_mult;                   // PLL multiplier
	logic [5:0]  rc_trim_code;               // Trim code
	logic [7:0]  osc_run_en;                 // Source run enables
	logic        slow_rc_run;                // Low-power RC run
	logic        clk_fail_trap;              // Trap pulse
	logic        trap_seen          = 1'b0;  // Sticky trap capture
	int          error_cnt          = 0;     // Mismatches
	int          n_tests            = 0;     // Comparisons
	logic [31:0] r;                          // Read scratch
	logic        e;                          // Error scratch
	logic [31:0] v;                          // Write scratch
	////////////////////////////////////////////////////////////////////////////////
	// Clock, design and trap capture
	always #2.5 mclk = ~mclk;
	osc_switch_pll_divider_ctrl u_osc_switch_pll_divider_ctrl (.mclk(mclk), .sys_rst(sys_rst), .por_rst(por_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .switch_monitor_cfg(switch_monitor_cfg),
		.initial_source_cfg(initial_source_cfg), .watchdog_on(watchdog_on), .irq_event(irq_event),
		.pll_locked(pll_locked), .osc_startup_done(osc_startup_done), .new_clk_tick(new_clk_tick),
		.osc_failed(osc_failed), .sys_clk_sel(sys_clk_sel), .cpu_div_ratio(cpu_div_ratio),
		.fast_rc_div(fast_rc_div), .pll_post_div(pll_post_div), .pll_pre_div(pll_pre_div), .pll_mult(pll_mult),
		.rc_trim_code(rc_trim_code), .osc_run_en(osc_run_en), .slow_rc_run(slow_rc_run),
		.clk_fail_trap(clk_fail_trap));
	// The trap lasts one cycle, so latch it for a later look
	always @(posedge mclk) begin
		if (clk_fail_trap === 1'b1) begin
			trap_seen <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One APB transfer; held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd_v, output logic er);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd_v = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		logic        te;
		apb(1'b1, a, d, t, te);
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d);
		logic te;
		apb(1'b0, a, 32'h0, d, te);
	endtask : rd
	// Unlocked write of new source, then unlocked low byte write
	task osc_wr(input logic [2:0] src, input logic [7:0] lo);
		wr(OFS_UNLOCK, 32'h1);
		wr(OFS_OSC_CTRL, {21'h0, src, 8'h00});
		wr(OFS_UNLOCK, 32'h2);
		wr(OFS_OSC_CTRL, {24'h0, lo});
	endtask : osc_wr
	// New clock edges slow enough for the two-stage synchroniser
	task ticks(input int n);
		repeat (n) begin
			new_clk_tick <= 1'b1;
			repeat (3) @(posedge mclk);
			new_clk_tick <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask : ticks
	task pulse(input logic por);
		por_rst <= por;
		sys_rst <= 1'b1;
		repeat (5) @(posedge mclk);
		por_rst <= 1'b0;
		sys_rst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : pulse
	task test_done;
		$display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////////////
	// Watchdog against a hung run
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		test_done();
	end
	// Main sequence
	initial begin
		pulse(1'b1);
		rd(OFS_CLK_DIV, r); chk("clk_div rst", r, 32'h3040);
		rd(OFS_PLL_FBD, r); chk("fbd rst", r, 32'h030);
		chk("mult rst", pll_mult, 50);
		chk("post rst", pll_post_div, 4);
		rd(OFS_RC_TRIM, r); chk("trim rst", r, 32'h0);
		$display("Test reset values done");
		// Every ratio, postscaler and postdivider code, with prescaler steps
		for (int i = 0; i < 8; i++) begin
			v = 32'((i << 12) | (1 << 11) | (i << 8) | ((i % 4) << 6) | (i * 4));
			wr(OFS_CLK_DIV, v);
			rd(OFS_CLK_DIV, r); chk("clk_div rw", r, v);
			chk("ratio", cpu_div_ratio, 32'h1 << i);
			chk("rc div", fast_rc_div, (i == 7) ? 32'd256 : (32'h1 << i));
			chk("post", pll_post_div, (i % 4 == 0) ? 32'd2 : (i % 4 == 1) ? 32'd4 : 32'd8);
			chk("pre", pll_pre_div, 32'(i * 4 + 2));
		end
		wr(OFS_CLK_DIV, 32'h701F);
		wr(OFS_PLL_FBD, 32'hFFFF_FFFF);
		wr(OFS_RC_TRIM, 32'hFFFF_FFE0);
		rd(OFS_PLL_FBD, r); chk("fbd max", r, 32'h1FF);
		chk("ratio off", cpu_div_ratio, 32'h1);
		chk("pre max", pll_pre_div, 32'd33);
		chk("mult max", pll_mult, 32'd513);
		chk("trim", rc_trim_code, 32'h20);
		pulse(1'b0);
		rd(OFS_CLK_DIV, r); chk("clk_div warm", r, 32'h701F);
		rd(OFS_RC_TRIM, r); chk("trim warm", r, 32'h20);
		$display("Test divider fields done");
		// Interrupt recovery only when enabled
		wr(OFS_CLK_DIV, 32'h3800);
		irq_event <= 1'b1;
		repeat (6) @(posedge mclk);
		irq_event <= 1'b0;
		rd(OFS_CLK_DIV, r); chk("no recover", r, 32'h3800);
		wr(OFS_CLK_DIV, 32'hB800);
		irq_event <= 1'b1;
		repeat (6) @(posedge mclk);
		irq_event <= 1'b0;
		rd(OFS_CLK_DIV, r); chk("recover", r, 32'hB000);
		chk("ratio 1:1", cpu_div_ratio, 32'h1);
		$display("Test recover on interrupt done");
		// Switching disabled by the strap
		osc_wr(SRC_PRI, 8'h01);
		rd(OFS_OSC_CTRL, r); chk("req held", r[0], 1'b0);
		initial_source_cfg <= SRC_FAST_D16;
		repeat (6) @(posedge mclk);
		rd(OFS_OSC_CTRL, r); chk("cur strap", r[14:12], SRC_FAST_D16);
		chk("sel strap", sys_clk_sel, SRC_FAST_D16);
		chk("slow rc off", slow_rc_run, 1'b0);
		watchdog_on <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("slow rc watchdog", slow_rc_run, 1'b1);
		watchdog_on <= 1'b0;
		$display("Test switching disabled done");
		// Enable switching and the monitor
		initial_source_cfg <= SRC_FAST;
		switch_monitor_cfg <= 1'b0;
		pulse(1'b1);
		wr(OFS_OSC_CTRL, 32'h0000_0101);
		rd(OFS_OSC_CTRL, r); chk("no unlock", r[10:0], 11'h0);
		chk("slow rc monitor", slow_rc_run, 1'b1);
		osc_wr(SRC_FAST, 8'h01);
		repeat (4) @(posedge mclk);
		rd(OFS_OSC_CTRL, r); chk("abort", r[0], 1'b0);
		chk("abort sel", sys_clk_sel, SRC_FAST);
		$display("Test redundant switch done");
		// Switch to fast RC with PLL; edges before lock must not count
		osc_wr(SRC_FAST_PLL, 8'h01);
		ticks(SETTLE_CYCLES);
		rd(OFS_OSC_CTRL, r); chk("wait lock", r[5], 1'b0);
		chk("req busy", r[0], 1'b1);
		chk("no change", sys_clk_sel, SRC_FAST);
		pll_locked <= 1'b1;
		repeat (5) @(posedge mclk);
		ticks(SETTLE_CYCLES - 1);
		chk("nine edges", sys_clk_sel, SRC_FAST);
		ticks(1);
		chk("tenth edge", sys_clk_sel, SRC_FAST_PLL);
		rd(OFS_OSC_CTRL, r); chk("done", {r[14:12], r[5], r[0]}, {SRC_FAST_PLL, 2'b10});
		chk("run en", osc_run_en, 8'h02);
		$display("Test clock switch done");
		// Failure while the PLL is in use
		osc_failed <= 1'b1;
		repeat (6) @(posedge mclk);
		osc_failed <= 1'b0;
		chk("trap", trap_seen, 1'b1);
		rd(OFS_OSC_CTRL, r); chk("fail flag", r[3], 1'b1);
		chk("fallback", r[14:12], SRC_FAST_PLL);
		osc_wr(SRC_FAST, 8'h09);
		repeat (2) @(posedge mclk);
		rd(OFS_OSC_CTRL, r); chk("fail cleared", r[3], 1'b0);
		ticks(SETTLE_CYCLES);
		chk("back to rc", sys_clk_sel, SRC_FAST);
		chk("old off", osc_run_en, 8'h01);
		$display("Test clock failure done");
		// Primary crystal waits for its start-up timer before counting
		osc_wr(SRC_PRI, 8'h01);
		ticks(SETTLE_CYCLES);
		chk("wait timer", sys_clk_sel, SRC_FAST);
		osc_startup_done <= 1'b1;
		repeat (5) @(posedge mclk);
		ticks(SETTLE_CYCLES);
		chk("primary", sys_clk_sel, SRC_PRI);
		// Failure without the PLL falls back to plain fast RC
		osc_failed <= 1'b1;
		repeat (6) @(posedge mclk);
		osc_failed <= 1'b0;
		rd(OFS_OSC_CTRL, r); chk("plain fallback", {r[14:12], r[3]}, {SRC_FAST, 1'b1});
		chk("sel fallback", sys_clk_sel, SRC_FAST);
		$display("Test primary switch and fallback done");
		// Unmapped place
		apb(1'b0, 8'h14, 32'h0, r, e);
		chk("slverr", e, 1'b1);
		chk("unmapped", r, 32'h0);
		$display("Test unmapped access done");
		test_done();
	end
endmodule : osc_switch_pll_divider_ctrl_bench
